// [bcod_defs.vh]
// constants for the opcode decoder and its state-count table
`ifndef BCOD_DEFS_VH
`define BCOD_DEFS_VH

// ----------------------------------------
// register select codes
// ----------------------------------------
`define BCOD_REG_B 3'h0
`define BCOD_REG_C 3'h1
`define BCOD_REG_D 3'h2
`define BCOD_REG_E 3'h3
`define BCOD_REG_H 3'h4
`define BCOD_REG_L 3'h5
`define BCOD_REG_MEM 3'h6
`define BCOD_REG_A 3'h7

// ----------------------------------------
// opcode groups and fixed patterns
// ----------------------------------------
`define BCOD_GRP_MISC 2'h0
`define BCOD_GRP_MOVE 2'h1
`define BCOD_GRP_ALU 2'h2
`define BCOD_GRP_CTRL 2'h3
`define BCOD_LO4_LOAD_PAIR 4'h1
`define BCOD_LO4_PUSH 4'h5
`define BCOD_LO3_RET 3'h0
`define BCOD_OPC_POP_BC 8'hc1

// ----------------------------------------
// operation codes on the op output
// ----------------------------------------
`define BCOD_OP_W 5
`define BCOD_OP_NONE 5'h00
`define BCOD_OP_MOVE 5'h01
`define BCOD_OP_STORE_MEM 5'h02
`define BCOD_OP_LOAD_MEM 5'h03
`define BCOD_OP_HALT 5'h04
`define BCOD_OP_ALU_REG 5'h05
`define BCOD_OP_ALU_MEM 5'h06
`define BCOD_OP_RET_COND 5'h07
`define BCOD_OP_LOAD_PAIR 5'h08
`define BCOD_OP_PUSH 5'h09
`define BCOD_OP_POP_BC 5'h0a

// ----------------------------------------
// accumulator operations (field value)
// ----------------------------------------
`define BCOD_ALU_ADD 3'h0
`define BCOD_ALU_ADC 3'h1
`define BCOD_ALU_SUB 3'h2
`define BCOD_ALU_SBB 3'h3
`define BCOD_ALU_AND 3'h4
`define BCOD_ALU_XOR 3'h5
`define BCOD_ALU_OR 3'h6
`define BCOD_ALU_CMP 3'h7

// ----------------------------------------
// return conditions
// ----------------------------------------
`define BCOD_CC_NZ 3'h0
`define BCOD_CC_Z 3'h1
`define BCOD_CC_PO 3'h4
`define BCOD_CC_PE 3'h5
`define BCOD_CC_P 3'h6
`define BCOD_CC_M 3'h7

// ----------------------------------------
// pair codes
// ----------------------------------------
`define BCOD_PAIR_BC 2'h0
`define BCOD_PAIR_DE 2'h1
`define BCOD_PAIR_HL 2'h2
`define BCOD_PAIR_SP_AF 2'h3

// ----------------------------------------
// state counts
// ----------------------------------------
`define BCOD_ST_W 4
`define BCOD_ST_0 4'h0
`define BCOD_ST_4 4'h4
`define BCOD_ST_5 4'h5
`define BCOD_ST_7 4'h7
`define BCOD_ST_10 4'ha
`define BCOD_ST_11 4'hb

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define BCOD_F_GROUP 7:6
`define BCOD_F_DEST 5:3
`define BCOD_F_SRC 2:0
`define BCOD_F_PAIR 5:4
`define BCOD_F_LO4 3:0
`define BCOD_SEL_RST 3'h0
`define BCOD_PAIR_RST 2'h0

`endif

// [bcod_field_split.v]
// field splitter: breaks an opcode byte into its select fields
`timescale 1ns/10ps
`default_nettype none
`include "bcod_defs.vh"

module bcod_field_split (
   input wire [7:0] opcode,
   output wire [1:0] group,
   output wire [2:0] dest_select_field,
   output wire [2:0] src_select_field,
   output wire [1:0] pair_field,
   output wire [3:0] low_nibble,
   output wire dest_is_mem,
   output wire src_is_mem
);
   assign group = opcode[`BCOD_F_GROUP];
   assign dest_select_field = opcode[`BCOD_F_DEST];
   assign src_select_field = opcode[`BCOD_F_SRC];
   assign pair_field = opcode[`BCOD_F_PAIR];
   assign low_nibble = opcode[`BCOD_F_LO4];
   // 110 means memory at the h/l address
   assign dest_is_mem = (opcode[`BCOD_F_DEST] == `BCOD_REG_MEM);
   assign src_is_mem = (opcode[`BCOD_F_SRC] == `BCOD_REG_MEM);
endmodule // bcod_field_split

`default_nettype wire

// [bcod_decode.v]
// opcode decoder: registered operation, fields and state counts
`timescale 1ns/10ps
`default_nettype none
`include "bcod_defs.vh"

module bcod_decode (
   input wire core_clk,
   input wire reset,
   input wire clk_en,
   input wire opcode_valid,
   input wire [7:0] opcode,
   output reg dec_valid_q,
   output reg [`BCOD_OP_W-1:0] op_q,
   output reg [2:0] alu_op_q,
   output reg [2:0] cond_q,
   output reg [2:0] dest_q,
   output reg [2:0] src_q,
   output reg [1:0] pair_q,
   output reg [`BCOD_ST_W-1:0] states_q,
   output reg [`BCOD_ST_W-1:0] states_alt_q,
   output reg dec_unknown_q
);

   // ----------------------------------------
   // field split
   // ----------------------------------------
   wire [1:0] group;
   wire [2:0] dest_select_field;
   wire [2:0] src_select_field;
   wire [1:0] pair_field;
   wire [3:0] low_nibble;
   wire dest_is_mem;
   wire src_is_mem;

   bcod_field_split u_split (
      .opcode(opcode),
      .group(group),
      .dest_select_field(dest_select_field),
      .src_select_field(src_select_field),
      .pair_field(pair_field),
      .low_nibble(low_nibble),
      .dest_is_mem(dest_is_mem),
      .src_is_mem(src_is_mem)
   );

   // 010 and 011 are not return conditions in this set
   function cond_ok;
      input [2:0] c;
      begin
         cond_ok = (c == `BCOD_CC_NZ) || (c == `BCOD_CC_Z) ||
                   (c == `BCOD_CC_PO) || (c == `BCOD_CC_PE) ||
                   (c == `BCOD_CC_P) || (c == `BCOD_CC_M);
      end
   endfunction

   // ----------------------------------------
   // state counts per operation
   // ----------------------------------------
   // one table holds every short count (the taken-return count sits in long_count), so a new operation costs one line
   function [`BCOD_ST_W-1:0] short_count;
      input [`BCOD_OP_W-1:0] op;
      begin
         case (op)
            `BCOD_OP_MOVE: short_count = `BCOD_ST_5;
            `BCOD_OP_STORE_MEM: short_count = `BCOD_ST_7;
            `BCOD_OP_HALT: short_count = `BCOD_ST_7;
            `BCOD_OP_LOAD_MEM: short_count = `BCOD_ST_7;
            `BCOD_OP_ALU_REG: short_count = `BCOD_ST_4;
            `BCOD_OP_ALU_MEM: short_count = `BCOD_ST_7;
            `BCOD_OP_RET_COND: short_count = `BCOD_ST_5;
            `BCOD_OP_LOAD_PAIR: short_count = `BCOD_ST_10;
            `BCOD_OP_PUSH: short_count = `BCOD_ST_11;
            `BCOD_OP_POP_BC: short_count = `BCOD_ST_10;
            // out-of-scope opcodes report zero states
            default: short_count = `BCOD_ST_0;
         endcase
      end
   endfunction

   // only a taken conditional return has a second, longer count
   function [`BCOD_ST_W-1:0] long_count;
      input [`BCOD_OP_W-1:0] op;
      begin
         if (op == `BCOD_OP_RET_COND) begin
            long_count = `BCOD_ST_11;
         end else begin
            long_count = `BCOD_ST_0;
         end
      end
   endfunction

   // ----------------------------------------
   // combinational decode
   // ----------------------------------------
   reg [`BCOD_OP_W-1:0] op_d;
   reg [`BCOD_ST_W-1:0] states_d;
   reg [`BCOD_ST_W-1:0] states_alt_d;

   always @* begin
      op_d = `BCOD_OP_NONE;
      case (group)
         `BCOD_GRP_MOVE: begin
            if (dest_is_mem && src_is_mem) begin
               op_d = `BCOD_OP_HALT;
            end else if (dest_is_mem) begin
               op_d = `BCOD_OP_STORE_MEM;
            end else if (src_is_mem) begin
               op_d = `BCOD_OP_LOAD_MEM;
            end else begin
               op_d = `BCOD_OP_MOVE;
            end
         end
         `BCOD_GRP_ALU: begin
            if (src_is_mem) begin
               op_d = `BCOD_OP_ALU_MEM;
            end else begin
               op_d = `BCOD_OP_ALU_REG;
            end
         end
         `BCOD_GRP_MISC: begin
            if (low_nibble == `BCOD_LO4_LOAD_PAIR) begin
               op_d = `BCOD_OP_LOAD_PAIR;
            end
         end
         `BCOD_GRP_CTRL: begin
            if (opcode == `BCOD_OPC_POP_BC) begin
               op_d = `BCOD_OP_POP_BC;
            end else if (low_nibble == `BCOD_LO4_PUSH) begin
               op_d = `BCOD_OP_PUSH;
            end else if (src_select_field == `BCOD_LO3_RET &&
                         cond_ok(dest_select_field)) begin
               op_d = `BCOD_OP_RET_COND;
            end
         end
         default: begin
            op_d = `BCOD_OP_NONE;
         end
      endcase
      // not taken: short count; taken: long count
      states_d = short_count(op_d);
      states_alt_d = long_count(op_d);
   end

   // ----------------------------------------
   // sample strobe
   // ----------------------------------------
   // one gate for op, field and count captures; the flag also waits for opcode_valid, valid uses clk_en alone, so a low enable freezes them all alike
   wire take = clk_en && opcode_valid;

   // ----------------------------------------
   // valid pulse and out-of-scope flag
   // ----------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         dec_valid_q <= 1'b0;
         dec_unknown_q <= 1'b0;
      end else if (clk_en) begin
         // valid is opcode_valid registered on each enabled cycle, a level that stays high across back-to-back bytes
         dec_valid_q <= opcode_valid;
         if (opcode_valid) begin
            // opcodes outside this decoder's scope are flagged
            dec_unknown_q <= (op_d == `BCOD_OP_NONE);
         end
      end
   end

   // ----------------------------------------
   // operation and state counts
   // ----------------------------------------
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         op_q <= `BCOD_OP_NONE;
         states_q <= `BCOD_ST_0;
         states_alt_q <= `BCOD_ST_0;
      end else if (take) begin
         op_q <= op_d;
         states_q <= states_d;
         states_alt_q <= states_alt_d;
      end
   end

   // ----------------------------------------
   // accumulator operation and return condition
   // ----------------------------------------
   // both copy the same bits; op_q tells which one is meant
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         alu_op_q <= `BCOD_SEL_RST;
         cond_q <= `BCOD_SEL_RST;
      end else if (take) begin
         alu_op_q <= dest_select_field;
         cond_q <= dest_select_field;
      end
   end

   // ----------------------------------------
   // register selects
   // ----------------------------------------
   // captured raw for every opcode, so the user reads them by op_q
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         dest_q <= `BCOD_SEL_RST;
         src_q <= `BCOD_SEL_RST;
      end else if (take) begin
         dest_q <= dest_select_field;
         src_q <= src_select_field;
      end
   end

   // ----------------------------------------
   // pair select
   // ----------------------------------------
   // meaningful only for pair loads and pushes
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pair_q <= `BCOD_PAIR_RST;
      end else if (take) begin
         pair_q <= pair_field;
      end
   end

endmodule // bcod_decode

`default_nettype wire

// [bcod_prog_mem.sv]
// program memory model that presents fetched opcode bytes
`timescale 1ns/10ps
`default_nettype none
module bcod_prog_mem (
   input wire logic core_clk,
   input wire logic run,
   input wire logic [7:0] mem_byte,
   output wire logic opcode_valid,
   output wire logic [7:0] opcode
);
   logic [7:0] last_q = 8'h00;
   always @(posedge core_clk) begin
      if (run) last_q <= mem_byte;
   end
   assign opcode_valid = run;
   // released bus shows the inverse of the last byte, so stale data never
   // looks like a fresh fetch
   assign opcode = run ? mem_byte : ~last_q;
endmodule // bcod_prog_mem
`default_nettype wire

// [bcod_decode_assertions.sv]
// concurrent checks on the opcode decoder ports
`timescale 1ns/10ps
`default_nettype none
`include "bcod_defs.vh"
module bcod_decode_chk (
   input wire core_clk,
   input wire reset,
   input wire clk_en,
   input wire opcode_valid,
   input wire [7:0] opcode,
   input wire dec_valid_q,
   input wire [`BCOD_OP_W-1:0] op_q,
   input wire [2:0] alu_op_q,
   input wire [2:0] cond_q,
   input wire [2:0] dest_q,
   input wire [2:0] src_q,
   input wire [1:0] pair_q,
   input wire [`BCOD_ST_W-1:0] states_q,
   input wire [`BCOD_ST_W-1:0] states_alt_q,
   input wire dec_unknown_q
);
   wire tk = clk_en && opcode_valid;
   wire [1:0] g = opcode[7:6];
   wire [2:0] lo = opcode[2:0];
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   move_copy_a: assert property (tk && g == 2'h1 && lo != 3'h6 &&
      opcode[5:3] != 3'h6 |=> op_q == `BCOD_OP_MOVE && states_q == 4'h5 &&
      {dest_q, src_q} == $past(opcode[5:0])) else $error("move bad");
   store_halt_a: assert property (tk && opcode[7:3] == 5'h0e |=>
      states_q == 4'h7 && op_q == ($past(lo) == 3'h6 ? `BCOD_OP_HALT :
      `BCOD_OP_STORE_MEM)) else $error("store or halt bad");
   load_mem_a: assert property (tk && g == 2'h1 && lo == 3'h6 &&
      opcode[5:3] != 3'h6 |=> op_q == `BCOD_OP_LOAD_MEM && states_q == 4'h7)
      else $error("load bad");
   alu_reg_a: assert property (tk && g == 2'h2 && lo != 3'h6 |=>
      op_q == `BCOD_OP_ALU_REG && states_q == 4'h4 &&
      alu_op_q == $past(opcode[5:3])) else $error("alu reg bad");
   alu_mem_a: assert property (tk && g == 2'h2 && lo == 3'h6 |=>
      op_q == `BCOD_OP_ALU_MEM && states_q == 4'h7 &&
      alu_op_q == $past(opcode[5:3])) else $error("alu mem bad");
   cond_ret_a: assert property (tk && g == 2'h3 && lo == 3'h0 &&
      opcode[5:4] != 2'h1 |=> op_q == `BCOD_OP_RET_COND && states_q == 4'h5
      && states_alt_q == 4'hb && cond_q == $past(opcode[5:3]))
      else $error("return bad");
   load_pair_a: assert property (tk && g == 2'h0 && opcode[3:0] == 4'h1
      |=> op_q == `BCOD_OP_LOAD_PAIR && states_q == 4'ha &&
      pair_q == $past(opcode[5:4])) else $error("pair load bad");
   push_pair_a: assert property (tk && g == 2'h3 && opcode[3:0] == 4'h5
      |=> op_q == `BCOD_OP_PUSH && states_q == 4'hb &&
      pair_q == $past(opcode[5:4])) else $error("push bad");
   pop_bc_a: assert property (tk && opcode == 8'hc1 |=>
      op_q == `BCOD_OP_POP_BC && states_q == 4'ha) else $error("pop bad");
   valid_pulse_a: assert property (clk_en |=>
      dec_valid_q == $past(opcode_valid)) else $error("valid pulse bad");
   freeze_hold_a: assert property (!clk_en |=>
      $stable(op_q) && $stable(dec_valid_q)) else $error("freeze bad");
endmodule // bcod_decode_chk
bind bcod_decode bcod_decode_chk u_chk (.*);
`default_nettype wire

// [tb.sv]
// self-checking bench for the opcode decoder
`timescale 1ns/10ps
`default_nettype none
`include "bcod_defs.vh"
module tb;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic run = 1'b0;
   logic [7:0] mem_byte = 8'h00;
   wire opcode_valid, dec_valid_q, dec_unknown_q;
   wire [7:0] opcode;
   wire [`BCOD_OP_W-1:0] op_q;
   wire [2:0] alu_op_q, cond_q, dest_q, src_q;
   wire [1:0] pair_q;
   wire [`BCOD_ST_W-1:0] states_q, states_alt_q;
   int err_total = 0;
   int total_checks = 0;
   bcod_prog_mem u_bcod_prog_mem (.*);
   bcod_decode u_bcod_decode (.*);
   initial forever #50 core_clk = ~core_clk;
   task automatic ck(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   // byte stays up across calls, so decodes run back to back
   task automatic send(input logic [7:0] b);
      mem_byte = b;
      run = 1'b1;
      @(negedge core_clk);
   endtask
   task automatic res(input logic [4:0] op, input logic [3:0] st, alt);
      ck(op_q === op && states_q === st && states_alt_q === alt &&
         dec_valid_q === 1'b1, "decode result");
      ck(dec_unknown_q === (op == `BCOD_OP_NONE), "scope flag");
   endtask
   task automatic t_move;
      logic [7:0] b;
      for (int i = 0; i < 64; i++) begin
         b = {2'h1, i[5:0]};
         send(b);
         if (b[5:3] == 3'h6) res(b[2:0] == 3'h6 ? `BCOD_OP_HALT :
            `BCOD_OP_STORE_MEM, 4'h7, 4'h0);
         else if (b[2:0] == 3'h6) res(`BCOD_OP_LOAD_MEM, 4'h7, 4'h0);
         else res(`BCOD_OP_MOVE, 4'h5, 4'h0);
         ck({dest_q, src_q} === b[5:0], "select fields");
      end
   endtask
   task automatic t_alu;
      logic [7:0] b;
      for (int i = 0; i < 64; i++) begin
         b = {2'h2, i[5:0]};
         send(b);
         if (b[2:0] == 3'h6) res(`BCOD_OP_ALU_MEM, 4'h7, 4'h0);
         else res(`BCOD_OP_ALU_REG, 4'h4, 4'h0);
         ck(alu_op_q === b[5:3], "alu field");
      end
   endtask
   task automatic t_ret;
      for (int c = 0; c < 8; c++) begin
         send({2'h3, c[2:0], 3'h0});
         if (c == 2 || c == 3) res(`BCOD_OP_NONE, 4'h0, 4'h0);
         else res(`BCOD_OP_RET_COND, 4'h5, 4'hb);
         ck(cond_q === c[2:0], "condition field");
      end
   endtask
   task automatic t_pairs;
      for (int p = 0; p < 4; p++) begin
         send({2'h0, p[1:0], 4'h1});
         res(`BCOD_OP_LOAD_PAIR, 4'ha, 4'h0);
         ck(pair_q === p[1:0], "load pair field");
         send({2'h3, p[1:0], 4'h5});
         res(`BCOD_OP_PUSH, 4'hb, 4'h0);
         ck(pair_q === p[1:0], "push pair field");
      end
      send(8'hc1);
      res(`BCOD_OP_POP_BC, 4'ha, 4'h0);
   endtask
   task automatic t_reset;
      send(8'h41);
      res(`BCOD_OP_MOVE, 4'h5, 4'h0);
      reset = 1'b1;
      run = 1'b0;
      @(negedge core_clk);
      ck(op_q === `BCOD_OP_NONE && states_q === 4'h0 && dec_valid_q === 1'b0
         && {alu_op_q, cond_q, dest_q, src_q, pair_q} === 14'h0000 &&
         states_alt_q === 4'h0 && dec_unknown_q === 1'b0, "reset values");
      reset = 1'b0;
      @(negedge core_clk);
   endtask
   task automatic t_freeze;
      send(8'h00);
      res(`BCOD_OP_NONE, 4'h0, 4'h0);
      ck(dec_unknown_q === 1'b1, "unknown flag");
      clk_en = 1'b0;
      send(8'hc1);
      ck(op_q === `BCOD_OP_NONE && dec_valid_q === 1'b1, "frozen");
      clk_en = 1'b1;
      run = 1'b0;
      @(negedge core_clk);
      ck(op_q === `BCOD_OP_NONE && dec_valid_q === 1'b0, "idle");
   endtask
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge core_clk);
      reset = 1'b0;
      t_move();
      t_alu();
      t_ret();
      t_pairs();
      t_reset();
      t_freeze();
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
